// >>> eia_checker.sv
// Port-level assertions for the interrupt pin, acknowledge and status logic
`timescale 1ns/1ps
`default_nettype none
module eia_checker (
   input wire logic        clk,                   // Core clock
   input wire logic        rstn,                  // Async reset, low
   input wire logic        ext_irq_in_a,          // Request pin a
   input wire logic [3:0]  ext_irq_polarity_bits, // Edge choice per pin
   input wire logic        core_svc,              // Service strobe
   input wire logic [3:0]  core_svc_slot,         // Serviced slot
   input wire logic [1:0]  core_pd_mode,          // Power-down mode
   input wire logic [15:0] int_events,            // Slot pulses
   input wire logic        irq_service_ack,       // Acknowledge
   input wire logic [3:0]  serviced_irq_number,   // Serviced number
   input wire logic        deep_sleep_status      // Power-down status
);
   logic [2:0] up_ff;   // Cycles since reset release, saturating
   logic [2:0] nxt_up;  // Next count
   logic       armed;   // Edge detector trusted
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Count up to seven, then hold
   always_comb nxt_up = (up_ff == 3'h7) ? up_ff : up_ff + 3'h1;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) up_ff <= 3'h0;
      else up_ff <= nxt_up;
   end
   assign armed = (up_ff == 3'h7);
   ack_after_svc_a: assert property (core_svc |=> irq_service_ack)
      else $error("no acknowledge after service");
   ack_has_cause_a: assert property (irq_service_ack |-> $past(core_svc))
      else $error("acknowledge without service");
   num_is_slot_a: assert property (core_svc |=> serviced_irq_number == $past(core_svc_slot))
      else $error("number differs from serviced slot");
   num_holds_a: assert property (!core_svc |=> $stable(serviced_irq_number))
      else $error("number moved without service");
   pd_high_a: assert property (core_pd_mode[1] |=> deep_sleep_status)
      else $error("status low in deep mode");
   pd_low_a: assert property (!core_pd_mode[1] |=> !deep_sleep_status)
      else $error("status high in light mode");
   pin_rise_a: assert property (armed && $rose(ext_irq_in_a) && !ext_irq_polarity_bits[0]
      |-> ##[4:5] int_events[4])
      else $error("selected edge missed");
   pin_fall_quiet_a: assert property (armed && $fell(ext_irq_in_a) && !ext_irq_polarity_bits[0]
      |-> ##3 !int_events[4] [*3])
      else $error("opposite edge fired");
   cover property (core_svc ##1 core_svc);
   cover property (armed && $rose(ext_irq_in_a));
   cover property ($rose(deep_sleep_status));
endmodule
bind eia_top eia_checker i_chk (.clk, .rstn, .ext_irq_in_a, .ext_irq_polarity_bits,
   .core_svc, .core_svc_slot, .core_pd_mode, .int_events, .irq_service_ack,
   .serviced_irq_number, .deep_sleep_status);
`default_nettype wire

// >>> eia_edge_detect.sv
// Synchronises the request pins and detects the selected edge on each
`timescale 1ns/1ps
`default_nettype none
module eia_edge_detect (
   input  wire logic clk,   // Core clock
   input  wire logic rstn,  // Asynchronous reset, active low
   eia_edge_if.det   eif    // Pins in, edge pulses out
);
   logic [eia_pkg::N_EXT-1:0] meta_ff;      // First sync stage, read only by sync_ff
   logic [eia_pkg::N_EXT-1:0] sync_ff;      // Second sync stage
   logic [eia_pkg::N_EXT-1:0] prev_ff;      // Level one cycle before sync_ff
   logic [eia_pkg::N_EXT-1:0] edge_ff;      // Registered edge pulses
   logic [eia_pkg::ARM_W-1:0] arm_ff;       // Counts fill of the chain after reset
   logic [eia_pkg::N_EXT-1:0] nxt_meta;
   logic [eia_pkg::N_EXT-1:0] nxt_sync;
   logic [eia_pkg::N_EXT-1:0] nxt_prev;
   logic [eia_pkg::N_EXT-1:0] nxt_edge;
   logic [eia_pkg::ARM_W-1:0] nxt_arm;
   logic                      armed;        // Chain holds real pin samples

   assign armed = (arm_ff == eia_pkg::ARM_CYCLES);

   // Next values: sync chain, then edge compare per pin
   always_comb begin
      nxt_meta = eif.pins;
      nxt_sync = meta_ff;
      nxt_prev = sync_ff;
      nxt_arm  = armed ? arm_ff : arm_ff + 2'h1;
      for (int i = 0; i < eia_pkg::N_EXT; i++) begin
         // A level held high at reset is not taken for an edge
         if (!armed) begin
            nxt_edge[i] = 1'b0;
         end else if (eif.pol[i] == eia_pkg::POL_RISE) begin
            nxt_edge[i] = sync_ff[i] & ~prev_ff[i];  // [R1]
         end else begin
            nxt_edge[i] = ~sync_ff[i] & prev_ff[i];  // [R1]
         end
      end
   end

   // Registers only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= '0;
         sync_ff <= '0;
         prev_ff <= '0;
         edge_ff <= '0;
         arm_ff  <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         prev_ff <= nxt_prev;
         edge_ff <= nxt_edge;
         arm_ff  <= nxt_arm;
      end
   end

   assign eif.edge_evt = edge_ff;
endmodule
`default_nettype wire

// >>> eia_edge_if.sv
// Carrier between the top and the pin edge detector
`timescale 1ns/1ps
`default_nettype none
interface eia_edge_if;
   logic [eia_pkg::N_EXT-1:0] pins;      // Raw request pins, unsynchronised
   logic [eia_pkg::N_EXT-1:0] pol;       // Per-pin active edge choice
   logic [eia_pkg::N_EXT-1:0] edge_evt;  // One-cycle pulse per detected edge
   // Detector side
   modport det (input pins, input pol, output edge_evt);
   // Top side
   modport top (output pins, output pol, input edge_evt);
endinterface
`default_nettype wire

// >>> eia_ext_model.sv
// External logic that raises the request pins
`timescale 1ns/1ps
`default_nettype none
module eia_ext_model (
   input wire logic       clk,   // Core clock
   input wire logic       go,    // Toggle request
   input wire logic [1:0] idx,   // Pin to toggle
   input wire logic       slow,  // Hold levels longer
   output var logic [3:0] pins,  // Request pins
   output logic           busy   // Still holding last level
);
   logic [2:0] hold;  // Cycles left before the next change
   initial pins = 4'h0;
   initial hold = 3'h0;
   assign busy = (hold != 3'h0);
   // Each level stands several cycles so both sides of an edge are sampled
   always @(posedge clk) begin
      if (hold != 3'h0) hold <= hold - 3'h1;
      else if (go) begin
         pins[idx] <= ~pins[idx];
         hold <= slow ? 3'h7 : 3'h6;
      end
   end
endmodule
`default_nettype wire

// >>> eia_pkg.sv
// Shared constants for the external interrupt and acknowledge pin logic
package eia_pkg;
   localparam int unsigned N_EXT      = 4;   // External request pins
   localparam int unsigned N_INT      = 16;  // Interrupt slots 0..15
   localparam int unsigned NUM_W      = 4;   // Width of the serviced number
   localparam int unsigned CODE_W     = 5;   // Width of a selector code
   localparam int unsigned FIRST_MASK = 4;   // First maskable, selectable slot
   localparam int unsigned LAST_MASK  = 15;  // Last maskable, selectable slot
   localparam int unsigned N_SRC      = 16;  // Source codes in use, 5'h10 up reserved
   localparam int unsigned PD_W       = 2;   // Width of the power-down mode code
   localparam int unsigned ARM_W      = 2;   // Width of the edge arming counter
   // Cycles the sync chain needs before a compare is trusted
   // Three fills: meta, sync and prev must all hold real pin samples
   localparam logic [1:0]  ARM_CYCLES = 2'h3;
   // Power-down mode codes reported by the core
   localparam logic [1:0]  PD_MODE2   = 2'h2;
   localparam logic [1:0]  PD_MODE3   = 2'h3;
   // Polarity bit value that selects a rising edge
   localparam logic        POL_RISE   = 1'b0;
   // Reset selector code for each selectable slot, slot 4 in the low field
   localparam logic [CODE_W*12-1:0] SEL_RESET = {
      5'h02, 5'h01, 5'h00, 5'h0b, 5'h0a, 5'h03,
      5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04};
   // Source code of the first external pin; the other pins follow in order
   localparam logic [CODE_W-1:0] EXT_CODE_BASE = 5'h04;
endpackage

// >>> eia_tb_top.sv
// Self-checking bench for the interrupt pin, acknowledge and status logic
`timescale 1ns/1ps
`default_nettype none
module ext_interrupt_ack_pins_tb_top;
   logic clk = 1'b0, rstn = 1'b0, go = 1'b0, sel_wr = 1'b0, core_svc = 1'b0;
   logic [3:0] pol = 4'h0, sel_slot = 4'h0, svc_slot = 4'h0, num, pins;
   logic [1:0] idx = 2'h0, pd = 2'h0;
   logic [4:0] sel_code = 5'h00;
   logic [15:0] pev = 16'h0000, ev, rnd = 16'hd7a8;
   logic ack, st, busy;
   int fail_count = 0, comparisons = 0, cyc = 0, k, s;
   int cnt[16], exp_n[16];  // Seen and expected pulses per slot
   eia_ext_model i_ext (.clk(clk), .go(go), .idx(idx), .slow(rnd[5]), .pins(pins), .busy(busy));
   eia_top i_dut (.clk(clk), .rstn(rstn), .ext_irq_in_a(pins[0]), .ext_irq_in_b(pins[1]),
      .ext_irq_in_c(pins[2]), .ext_irq_in_d(pins[3]), .ext_irq_polarity_bits(pol),
      .periph_irq_events(pev), .sel_wr(sel_wr), .sel_slot(sel_slot), .sel_code(sel_code),
      .core_svc(core_svc), .core_svc_slot(svc_slot), .core_pd_mode(pd), .int_events(ev),
      .irq_service_ack(ack), .serviced_irq_number(num), .deep_sleep_status(st));
   always #5 clk = ~clk;
   // Tally slot pulses and cut a hang short
   always @(posedge clk) begin
      for (int j = 0; j < 16; j++) if (ev[j] === 1'b1) cnt[j]++;
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         report_and_stop();
      end
   end
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      comparisons++;
      if (got !== want) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, want);
      end
   endtask
   // Reset with a fresh random polarity, outputs checked low meanwhile
   task automatic do_reset();
      rstn = 1'b0;
      rnd = lfsr(rnd);
      pol = rnd[3:0];
      repeat (16) @(negedge clk);
      chk(ev, 16'h0000);
      chk({10'h000, ack, num, st}, 16'h0000);
      rstn = 1'b1;
      repeat (16) @(negedge clk);
   endtask
   // Toggle a random pin and book the pulse it should give
   task automatic tog();
      while (busy) @(negedge clk);
      rnd = lfsr(rnd);
      idx = rnd[1:0];
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      if (pins[idx] !== pol[idx]) exp_n[4 + idx]++;
   endtask
   task automatic cmp_counts();
      repeat (12) @(negedge clk);
      for (k = 0; k < 16; k++) chk(cnt[k][15:0], exp_n[k][15:0]);
   endtask
   task automatic report_and_stop();
      if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      for (k = 0; k < 16; k++) begin
         cnt[k] = 0;
         exp_n[k] = 0;
      end
      for (int p = 0; p < 2; p++) begin
         do_reset();
         repeat (14) tog();
         cmp_counts();
      end
      // Back-to-back service of every slot, then random slots
      for (k = 0; k < 24; k++) begin
         rnd = lfsr(rnd);
         s = (k < 16) ? k : rnd[3:0];
         core_svc = 1'b1;
         svc_slot = s[3:0];
         @(negedge clk);
         chk(ack, 1'b1);
         chk(num, s[3:0]);
      end
      core_svc = 1'b0;
      repeat (3) @(negedge clk);
      chk({ack, num}, {1'b0, s[3:0]});
      for (k = 0; k < 4; k++) begin
         pd = k[1:0];
         @(negedge clk);
         chk(st, k >= 2);
      end
      // Default slot 8 route, a move, a reserved code and a refused slot
      pev = 16'h0100;
      exp_n[8]++;
      @(negedge clk);
      pev = 16'h0;
      for (k = 0; k < 3; k++) begin
         sel_wr = 1'b1;
         sel_slot = (k == 2) ? 4'h2 : 4'h9;
         sel_code = (k == 1) ? 5'h10 : 5'h0e;
         @(negedge clk);
         sel_wr = 1'b0;
         pev = 16'h4000;
         if (k == 0) exp_n[9]++;
         @(negedge clk);
         pev = 16'h0;
      end
      cmp_counts();
      report_and_stop();
   end
endmodule
`default_nettype wire

// >>> eia_top.sv
// External interrupt pins, source selection, acknowledge and power-down status
//
// Operation
// [R1] Each request pin edge-detected, per-pin polarity bit
// [R2] Acknowledge pulses for every serviced interrupt
// [R3] Number valid throughout every acknowledge
// [R4] Number equals the serviced fetch-packet slot
// [R5] Status high in power-down modes 2, 3
// [R6] Reset selectors route pins to slots 4-7
// [R7] Requests idle long enough before each edge
`timescale 1ns/1ps
`default_nettype none
module eia_top (
   input  wire logic                               clk,                   // Core clock
   input  wire logic                               rstn,                  // Async reset, low
   input  wire logic                               ext_irq_in_a,          // Request pin a
   input  wire logic                               ext_irq_in_b,          // Request pin b
   input  wire logic                               ext_irq_in_c,          // Request pin c
   input  wire logic                               ext_irq_in_d,          // Request pin d
   input  wire logic [eia_pkg::N_EXT-1:0]          ext_irq_polarity_bits, // 0 rise, 1 fall
   input  wire logic [eia_pkg::N_SRC-1:0]          periph_irq_events,     // On-chip source pulses
   input  wire logic                               sel_wr,                // Selector write strobe
   input  wire logic [eia_pkg::NUM_W-1:0]          sel_slot,              // Slot to reprogram
   input  wire logic [eia_pkg::CODE_W-1:0]         sel_code,              // New source code
   input  wire logic                               core_svc,              // Core services a slot
   input  wire logic [eia_pkg::NUM_W-1:0]          core_svc_slot,         // Slot being serviced
   input  wire logic [eia_pkg::PD_W-1:0]           core_pd_mode,          // Current power-down mode
   output logic      [eia_pkg::N_INT-1:0]          int_events,            // Pulses per slot
   output logic                                    irq_service_ack,       // Acknowledge pin
   output logic      [eia_pkg::NUM_W-1:0]          serviced_irq_number,   // Serviced number pins
   output logic                                    deep_sleep_status      // Power-down pin
);

   // Source code for slot n sits in field n-4 of sel_ff; N_SEL counts the fields
   localparam int unsigned N_SEL = eia_pkg::LAST_MASK - eia_pkg::FIRST_MASK + 1;

   // Picks the source pulse named by a code; reserved codes give nothing
   function automatic logic pick_src(
      input logic [eia_pkg::CODE_W-1:0] code,
      input logic [eia_pkg::N_SRC-1:0]  src
   );
      logic hit;
      hit = 1'b0;
      if (code < eia_pkg::CODE_W'(eia_pkg::N_SRC)) begin
         hit = src[code[eia_pkg::NUM_W-1:0]];
      end
      return hit;
   endfunction

   // True when a slot number may be reprogrammed
   function automatic logic slot_selectable(input logic [eia_pkg::NUM_W-1:0] slot);
      return (slot >= eia_pkg::NUM_W'(eia_pkg::FIRST_MASK));
   endfunction

   // ------------------------------------------------------------------
   // Pin edge detection
   // ------------------------------------------------------------------
   eia_edge_if eif ();  // Carrier to the detector

   // Pins and polarity go to the detector untouched; it synchronises the pins, not the polarity
   assign eif.pins = {ext_irq_in_d, ext_irq_in_c, ext_irq_in_b, ext_irq_in_a};
   assign eif.pol  = ext_irq_polarity_bits;

   // Detector instance; relies on each pin idling before its edge
   eia_edge_detect u_edge (  // [R7]
      .clk  (clk),
      .rstn (rstn),
      .eif  (eif)
   );

   // ------------------------------------------------------------------
   // Source vector indexed by selector code
   // ------------------------------------------------------------------
   logic [eia_pkg::N_SRC-1:0] src_vec;  // Every event by its code

   // External pins occupy codes 4..7, on-chip sources the rest
   always_comb begin
      src_vec = periph_irq_events;
      for (int p = 0; p < eia_pkg::N_EXT; p++) begin
         src_vec[eia_pkg::EXT_CODE_BASE + p] = eif.edge_evt[p];
      end
   end

   // ------------------------------------------------------------------
   // Selector codes for slots 4..15
   // ------------------------------------------------------------------
   logic [eia_pkg::CODE_W*N_SEL-1:0] sel_ff;   // Current code per slot
   logic [eia_pkg::CODE_W*N_SEL-1:0] nxt_sel;  // Next codes
   logic [eia_pkg::NUM_W-1:0]        sel_idx;  // Field index of the written slot

   assign sel_idx = sel_slot - eia_pkg::NUM_W'(eia_pkg::FIRST_MASK);

   // Replace one field on a write to a selectable slot
   always_comb begin
      nxt_sel = sel_ff;
      if (sel_wr && slot_selectable(sel_slot)) begin
         nxt_sel[sel_idx*eia_pkg::CODE_W +: eia_pkg::CODE_W] = sel_code;
      end
   end

   // Selector registers come up routing the pins to slots 4..7
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_ff <= eia_pkg::SEL_RESET;  // [R6]
      end else begin
         sel_ff <= nxt_sel;
      end
   end

   // ------------------------------------------------------------------
   // Per-slot event pulses toward the core
   // ------------------------------------------------------------------
   logic [eia_pkg::N_INT-1:0] int_ev_ff;   // Registered slot pulses
   logic [eia_pkg::N_INT-1:0] nxt_int_ev;  // Next slot pulses

   // Slots 0..3 are fixed and not fed from here
   assign nxt_int_ev[eia_pkg::FIRST_MASK-1:0] = '0;

   // One selector per maskable slot
   for (genvar s = 0; s < N_SEL; s++) begin : g_slot
      assign nxt_int_ev[eia_pkg::FIRST_MASK + s] =
         pick_src(sel_ff[s*eia_pkg::CODE_W +: eia_pkg::CODE_W], src_vec);  // [R6]
   end

   // Register the slot pulses
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         int_ev_ff <= '0;
      end else begin
         int_ev_ff <= nxt_int_ev;
      end
   end

   assign int_events = int_ev_ff;

   // ------------------------------------------------------------------
   // Acknowledge and serviced number
   // ------------------------------------------------------------------
   logic                      ack_ff;   // Acknowledge pin level
   logic [eia_pkg::NUM_W-1:0] num_ff;   // Number pins
   logic                      nxt_ack;
   logic [eia_pkg::NUM_W-1:0] nxt_num;

   // Any serviced slot, NMI and on-chip ones included, is acknowledged
   always_comb begin
      nxt_ack = core_svc;  // [R2]
      nxt_num = num_ff;
      if (core_svc) begin
         // Slot index is the fetch-packet position, loaded with the ack
         nxt_num = core_svc_slot;  // [R3] [R4]
      end
   end

   // Number changes only on a new service, so it holds under the ack
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_ff <= 1'b0;
         num_ff <= '0;
      end else begin
         ack_ff <= nxt_ack;
         num_ff <= nxt_num;
      end
   end

   assign irq_service_ack     = ack_ff;
   assign serviced_irq_number = num_ff;

   // ------------------------------------------------------------------
   // Power-down status
   // ------------------------------------------------------------------
   logic pd_ff;   // Status pin level
   logic nxt_pd;

   // High only for the two deepest modes
   always_comb begin
      nxt_pd = (core_pd_mode == eia_pkg::PD_MODE2) ||
               (core_pd_mode == eia_pkg::PD_MODE3);  // [R5]
   end

   // Register the status
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pd_ff <= 1'b0;
      end else begin
         pd_ff <= nxt_pd;
      end
   end

   assign deep_sleep_status = pd_ff;

endmodule
`default_nettype wire
